// File: rtl/synth_top.sv
// Purpose: Keyboard/demo music synthesizer with codec, display and bus.
// Assumes: Keyboard frames arrive on their own clock; switches are pins.
// Notes:   Note codes 1..19 run from low sharp 4 to high 1; 0 is silence.
`timescale 1ns/100ps
module synth_top #(
    parameter int unsigned NOTE_CYCLES = synth_pkg::NOTE_CYCLES_DEF
) (
    input  wire logic        MCLK,          // System clock
    input  wire logic        SYS_RST,       // Async reset, active high
    input  wire logic        KBD_CLK,       // Keyboard link clock
    input  wire logic        KBD_DATA,      // Keyboard serial data
    input  wire logic        SRC_SEL_SW,    // Source select switch
    input  wire logic        TIMBRE_SW,     // Timbre switch
    input  wire logic        CH1_OFF_SW,    // First channel switch
    input  wire logic        CH2_OFF_SW,    // Second channel switch
    input  wire logic        REPLAY_BTN_N,  // Replay button, low pressed
    input  wire logic [synth_pkg::ADDR_W-1:0] AVS_ADDRESS, // Byte addr
    input  wire logic        AVS_READ,      // Read request
    input  wire logic        AVS_WRITE,     // Write request
    input  wire logic [31:0] AVS_WRITEDATA, // Write data
    input  wire logic [3:0]  AVS_BYTEENABLE,// Byte lanes
    output logic      [31:0] AVS_READDATA,  // Read data
    output logic             AVS_WAITREQUEST, // Stall
    output logic             AUD_BCLK,      // Codec bit clock
    output logic             AUD_LRCK,      // Codec channel clock
    output logic             AUD_DATA,      // Codec serial data
    output logic             VGA_HS,        // Horizontal sync
    output logic             VGA_VS,        // Vertical sync
    output logic      [3:0]  VGA_R,         // Red
    output logic      [3:0]  VGA_G,         // Green
    output logic      [3:0]  VGA_B          // Blue
);
    import synth_pkg::*;

    function automatic logic [4:0] scan_to_note(input logic [7:0] sc);
        case (sc)
            8'h15: scan_to_note = 5'h01;
            8'h1c: scan_to_note = 5'h02;
            8'h1d: scan_to_note = 5'h03;
            8'h1b: scan_to_note = 5'h04;
            8'h24: scan_to_note = 5'h05;
            8'h23: scan_to_note = 5'h06;
            8'h2b: scan_to_note = 5'h07;
            8'h2c: scan_to_note = 5'h08;
            8'h34: scan_to_note = 5'h09;
            8'h35: scan_to_note = 5'h0a;
            8'h33: scan_to_note = 5'h0b;
            8'h3b: scan_to_note = 5'h0c;
            8'h43: scan_to_note = 5'h0d;
            8'h42: scan_to_note = 5'h0e;
            8'h44: scan_to_note = 5'h0f;
            8'h4b: scan_to_note = 5'h10;
            8'h4d: scan_to_note = 5'h11;
            8'h4c: scan_to_note = 5'h12;
            8'h3c: scan_to_note = 5'h13;
            default: scan_to_note = 5'h00;
        endcase
    endfunction

    // Phase step per MCLK for a 32-bit accumulator
    function automatic logic [31:0] note_step(input logic [4:0] n);
        case (n)
            5'h01: note_step = 32'h00000c6a;
            5'h02: note_step = 32'h00000d27;
            5'h03: note_step = 32'h00000def;
            5'h04: note_step = 32'h00000ec4;
            5'h05: note_step = 32'h00000fa4;
            5'h06: note_step = 32'h00001092;
            5'h07: note_step = 32'h0000118f;
            5'h08: note_step = 32'h0000129a;
            5'h09: note_step = 32'h000013b5;
            5'h0a: note_step = 32'h000014e1;
            5'h0b: note_step = 32'h0000161f;
            5'h0c: note_step = 32'h00001770;
            5'h0d: note_step = 32'h000018d4;
            5'h0e: note_step = 32'h00001a4f;
            5'h0f: note_step = 32'h00001bdf;
            5'h10: note_step = 32'h00001d87;
            5'h11: note_step = 32'h00001f49;
            5'h12: note_step = 32'h00002125;
            5'h13: note_step = 32'h0000231d;
            default: note_step = 32'h00000000;
        endcase
    endfunction

    function automatic logic [4:0] demo_tune(input logic [3:0] i);
        case (i)
            4'h0: demo_tune = 5'h07;
            4'h1: demo_tune = 5'h07;
            4'h2: demo_tune = 5'h0e;
            4'h3: demo_tune = 5'h0e;
            4'h4: demo_tune = 5'h10;
            4'h5: demo_tune = 5'h10;
            4'h6: demo_tune = 5'h0e;
            4'h7: demo_tune = 5'h00;
            4'h8: demo_tune = 5'h0c;
            4'h9: demo_tune = 5'h0c;
            4'ha: demo_tune = 5'h0b;
            4'hb: demo_tune = 5'h0b;
            4'hc: demo_tune = 5'h09;
            4'hd: demo_tune = 5'h09;
            4'he: demo_tune = 5'h07;
            default: demo_tune = 5'h00;
        endcase
    endfunction

    // Keyboard link domain; clock stops between frames, so no timeout
    logic [3:0] kb_bit_ff;
    logic [9:0] kb_sh_ff;
    logic [7:0] kb_byte_ff;
    logic       kb_tog_ff;
    always_ff @(negedge KBD_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            kb_bit_ff <= 4'h0;
            kb_sh_ff  <= 10'h000;
        end else if (kb_bit_ff == KB_LAST) begin
            kb_bit_ff <= 4'h0;
        end else begin
            kb_bit_ff <= kb_bit_ff + 4'h1;
            kb_sh_ff  <= {KBD_DATA, kb_sh_ff[9:1]};
        end
    end
    always_ff @(negedge KBD_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            kb_byte_ff <= 8'h00;
            kb_tog_ff  <= 1'b0;
        end else if (kb_bit_ff == KB_LAST && !kb_sh_ff[0] && KBD_DATA
                     && ^kb_sh_ff[9:1]) begin
            kb_byte_ff <= kb_sh_ff[8:1];
            kb_tog_ff  <= ~kb_tog_ff;
        end
    end

    // Toggle crossing; byte is stable long before the toggle lands
    logic [2:0] tog_sync_ff;
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) tog_sync_ff <= 3'h0;
        else         tog_sync_ff <= {tog_sync_ff[1:0], kb_tog_ff};
    end
    logic       byte_new;
    logic [4:0] byte_note;
    assign byte_new  = tog_sync_ff[2] ^ tog_sync_ff[1];
    assign byte_note = scan_to_note(kb_byte_ff);

    // Switch and button pins: two flops before use
    logic [4:0] pin_meta_ff;
    logic [4:0] pin_ff;
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pin_meta_ff <= 5'h00;
            pin_ff      <= 5'h00;
        end else begin
            pin_meta_ff <= {~REPLAY_BTN_N, CH2_OFF_SW, CH1_OFF_SW,
                            TIMBRE_SW, SRC_SEL_SW};
            pin_ff      <= pin_meta_ff;
        end
    end
    logic src_kbd, timbre_str, ch1_off, ch2_off, btn;
    assign {btn, ch2_off, ch1_off, timbre_str, src_kbd} = pin_ff;

    logic btn_d_ff;
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) btn_d_ff <= 1'b0;
        else         btn_d_ff <= btn;
    end

    // Register bus: every request answered at the second edge
    logic        ack_ff;
    logic        mute_ff;
    logic        soft_replay_ff;
    logic        bus_req;
    logic        wr_ctrl;
    assign bus_req         = AVS_READ | AVS_WRITE;
    assign AVS_WAITREQUEST = bus_req & ~ack_ff;
    assign wr_ctrl = AVS_WRITE & ack_ff & (AVS_ADDRESS == REG_CTRL)
                   & AVS_BYTEENABLE[0];
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) ack_ff <= 1'b0;
        else         ack_ff <= bus_req & ~ack_ff;
    end
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            mute_ff        <= CTRL_MUTE_RST;
            soft_replay_ff <= 1'b0;
        end else begin
            soft_replay_ff <= wr_ctrl & AVS_WRITEDATA[CTRL_REPLAY];
            if (wr_ctrl) mute_ff <= AVS_WRITEDATA[CTRL_MUTE];
        end
    end
    logic replay;
    assign replay = (btn & ~btn_d_ff) | soft_replay_ff;

    // Keyboard note tracking: break code releases the held key
    logic       brk_ff;
    logic [4:0] kbd_note_ff;
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin // R05
            brk_ff      <= 1'b0;
            kbd_note_ff <= 5'h00;
        end else if (byte_new) begin
            if (kb_byte_ff == SC_BREAK) begin
                brk_ff <= 1'b1;
            end else begin
                brk_ff <= 1'b0;
                if (brk_ff && byte_note == kbd_note_ff)
                    kbd_note_ff <= 5'h00;
                else if (!brk_ff && byte_note != 5'h00)
                    kbd_note_ff <= byte_note; // R06
            end
        end
    end

    // Demo player; idle after reset until a replay press or a control write with the replay bit
    demo_state_type demo_st_ff;
    logic [3:0]     demo_idx_ff;
    logic [31:0]    beat_ff;
    logic           beat_end;
    assign beat_end = beat_ff == NOTE_CYCLES - 32'h1;
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            demo_st_ff  <= DEMO_IDLE;
            demo_idx_ff <= 4'h0;
            beat_ff     <= 32'h0;
        end else if (replay) begin // R02
            demo_st_ff  <= DEMO_PLAY;
            demo_idx_ff <= 4'h0;
            beat_ff     <= 32'h0;
        end else begin
            case (demo_st_ff)
                DEMO_PLAY: begin
                    beat_ff <= beat_end ? 32'h0 : beat_ff + 32'h1;
                    if (beat_end) begin // R08
                        demo_idx_ff <= demo_idx_ff + 4'h1;
                        if (demo_idx_ff == DEMO_LAST)
                            demo_st_ff <= DEMO_IDLE;
                    end
                end
                default: beat_ff <= 32'h0;
            endcase
        end
    end
    logic [4:0] demo_note;
    assign demo_note = (demo_st_ff == DEMO_PLAY) ?
                       demo_tune(demo_idx_ff) : 5'h00; // R08

    logic [4:0] note_ff;
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) note_ff <= 5'h00;
        else         note_ff <= src_kbd ? kbd_note_ff : demo_note; // R01
    end

    // Tone synthesis
    logic [31:0] phase_ff;
    logic [15:0] sample_ff;
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST)               phase_ff <= 32'h0;
        else if (note_ff == 5'h00) phase_ff <= 32'h0;
        else                       phase_ff <= phase_ff + note_step(note_ff);
    end
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST)               sample_ff <= 16'h0000;
        else if (note_ff == 5'h00) sample_ff <= 16'h0000;
        else if (timbre_str)       // R03
            sample_ff <= {{3{~phase_ff[31]}}, phase_ff[30:18]};
        else
            sample_ff <= phase_ff[31] ? BRASS_HI : BRASS_LO;
    end

    // Codec serial port; sample held whole for its frame
    logic [7:0]  bclk_cnt_ff;
    logic        bclk_ff;
    logic [4:0]  bit_ff;
    logic [31:0] aud_sh_ff;
    logic        lrck_ff;
    logic        bclk_fall;
    logic [4:0]  nxt_bit;
    logic [15:0] left_smp, right_smp;
    assign bclk_fall = (bclk_cnt_ff == BCLK_HALF - 8'h1) & bclk_ff;
    assign nxt_bit   = bit_ff + 5'h1;
    assign left_smp  = (ch1_off | mute_ff) ? 16'h0000 : sample_ff; // R04
    assign right_smp = (ch2_off | mute_ff) ? 16'h0000 : sample_ff; // R04
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            bclk_cnt_ff <= 8'h00;
            bclk_ff     <= 1'b0;
        end else if (bclk_cnt_ff == BCLK_HALF - 8'h1) begin // R09
            bclk_cnt_ff <= 8'h00;
            bclk_ff     <= ~bclk_ff;
        end else begin
            bclk_cnt_ff <= bclk_cnt_ff + 8'h1;
        end
    end
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            bit_ff    <= 5'h1f;
            aud_sh_ff <= 32'h0;
            lrck_ff   <= 1'b0;
        end else if (bclk_fall) begin // R09
            bit_ff    <= nxt_bit;
            lrck_ff   <= ~nxt_bit[4];
            aud_sh_ff <= (bit_ff == 5'h1f) ? {left_smp, right_smp}
                                            : {aud_sh_ff[30:0], 1'b0};
        end
    end
    assign AUD_BCLK = bclk_ff;
    assign AUD_LRCK = lrck_ff;
    assign AUD_DATA = aud_sh_ff[31];

    // Display: twenty 32-pixel key slots in the lower third
    logic [3:0] pix_ff;
    logic [9:0] h_ff, v_ff;
    logic       pix_tick;
    logic       hs_ff, vs_ff;
    logic [11:0] rgb_ff;
    logic [4:0]  slot;
    assign pix_tick = pix_ff == PIX_DIV;
    assign slot     = h_ff[9:5] + 5'h1;
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pix_ff <= 4'h0;
            h_ff   <= 10'h000;
            v_ff   <= 10'h000;
        end else begin
            pix_ff <= pix_tick ? 4'h0 : pix_ff + 4'h1;
            if (pix_tick) begin
                h_ff <= (h_ff == H_TOTAL - 10'h1) ? 10'h000 : h_ff + 10'h1;
                if (h_ff == H_TOTAL - 10'h1)
                    v_ff <= (v_ff == V_TOTAL - 10'h1) ? 10'h000
                                                      : v_ff + 10'h1;
            end
        end
    end
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            hs_ff  <= 1'b1;
            vs_ff  <= 1'b1;
            rgb_ff <= 12'h000;
        end else if (pix_tick) begin
            hs_ff <= !(h_ff >= H_SYN_BEG && h_ff < H_SYN_END);
            vs_ff <= !(v_ff >= V_SYN_BEG && v_ff < V_SYN_END);
            if (h_ff >= H_ACTIVE || v_ff >= V_ACTIVE)
                rgb_ff <= 12'h000;
            else if (v_ff < KEY_TOP)
                rgb_ff <= 12'h004;
            else if (h_ff[4:0] == 5'h00)
                rgb_ff <= 12'h000;
            else if (slot == note_ff) // R07
                rgb_ff <= 12'hf00;
            else
                rgb_ff <= 12'hfff;
        end
    end
    assign VGA_HS = hs_ff;
    assign VGA_VS = vs_ff;
    assign {VGA_R, VGA_G, VGA_B} = rgb_ff;

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            AVS_READDATA <= 32'h0;
        end else if (AVS_READ & ~ack_ff) begin
            if (AVS_ADDRESS == REG_STAT)
                AVS_READDATA <= {24'h0, src_kbd, demo_st_ff == DEMO_PLAY,
                                 kbd_note_ff != 5'h00, note_ff};
            else if (AVS_ADDRESS == REG_CTRL)
                AVS_READDATA <= {30'h0, mute_ff, 1'b0};
            else
                AVS_READDATA <= 32'h0;
        end
    end

    default clocking @(posedge MCLK); endclocking
    default disable iff (SYS_RST);

    AST_SRC_SEL: assert property ( // R01
        $stable(src_kbd) && $stable(kbd_note_ff) && $stable(demo_note)
        |-> note_ff == (src_kbd ? kbd_note_ff : demo_note))
        else $error("note source does not follow switch");
    AST_REPLAY: assert property ( // R02
        replay |=> demo_st_ff == DEMO_PLAY && demo_idx_ff == 4'h0
                   && beat_ff == 32'h0)
        else $error("replay did not restart tune");
    AST_TIMBRE: assert property ( // R03
        note_ff != 5'h00 && !timbre_str |=>
        sample_ff == BRASS_HI || sample_ff == BRASS_LO)
        else $error("brass wave wrong");
    AST_CH_OFF: assert property ( // R04
        bclk_fall && bit_ff == 5'h1f && ch1_off |=> aud_sh_ff[31:16] == 0)
        else $error("silenced channel carries data");
    AST_RESET: assert property (disable iff (1'b0) // R05
        $fell(SYS_RST) |-> demo_st_ff == DEMO_IDLE && note_ff == 5'h00
                          && kbd_note_ff == 5'h00)
        else $error("state not initial after reset");
    AST_KEY_MAP: assert property ( // R06
        byte_new && !brk_ff && kb_byte_ff == 8'h3c |=> kbd_note_ff == 5'h13)
        else $error("high key not mapped");
    AST_DISPLAY: assert property ( // R07
        pix_tick && h_ff < H_ACTIVE && v_ff >= KEY_TOP && v_ff < V_ACTIVE
        && h_ff[4:0] != 5'h00 && slot == note_ff |=> rgb_ff == 12'hf00)
        else $error("held key not marked");
    AST_DEMO_STEP: assert property ( // R08
        demo_st_ff == DEMO_PLAY && beat_end && !replay
        |=> demo_idx_ff == $past(demo_idx_ff) + 4'h1)
        else $error("demo tune did not advance");
    // Cycles the bit clock has held its level; long waits stay cheap
    logic       bclk_seen_ff;
    logic [7:0] bclk_run_ff;
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            bclk_seen_ff <= 1'b0;
            bclk_run_ff  <= 8'h00;
        end else begin
            bclk_seen_ff <= bclk_ff;
            bclk_run_ff  <= (bclk_ff != bclk_seen_ff) ? 8'h01
                                                      : bclk_run_ff + 8'h01;
        end
    end
    AST_BCLK: assert property ( // R09
        bclk_ff != bclk_seen_ff |-> bclk_run_ff == BCLK_HALF)
        else $error("bit clock period wrong");
    AST_LRCK: assert property ( // R09
        bclk_fall && bit_ff == 5'h1f |=> lrck_ff && bit_ff == 5'h00)
        else $error("frame not aligned to channel clock");

    COV_KEY:    cover property (byte_new && byte_note != 5'h00 && !brk_ff);
    COV_DEMO:   cover property (demo_st_ff == DEMO_PLAY && beat_end);
    COV_STRING: cover property (timbre_str && note_ff != 5'h00);
    COV_BUS:    cover property (AVS_READ && ack_ff);
endmodule // synth_top

// File: rtl/synth_pkg.sv
// Purpose: Shared constants for the keyboard music synthesizer.
// Assumes: MCLK at 250 MHz, 640x480 display timing from a /10 tick.
// Notes:   Register offsets are byte addresses on a 32-bit bus.
// Function
// R01 - Switch 0 plays the demo tune, switch 1 plays the keyboard.
// R02 - Replay button restarts the demo tune from its first note.
// R03 - Timbre switch 0 gives brass, 1 gives string.
// R04 - Each codec channel has a switch: 0 sounds, 1 silences.
// R05 - Reset returns the whole synthesizer to its initial state.
// R06 - Nineteen keyboard keys map to notes from low sharp 4 to high 1.
// R07 - While a key is held, the display marks it on a keyboard drawing; code marks note_ff, so in demo mode it marks the demo note.
// R08 - A fixed sample melody is stored and played as the demo.
// R09 - Device makes bit and channel clocks, one sample per channel per frame.
package synth_pkg;
    localparam int CLK_MHZ         = 250;
    localparam int NOTE_TIME_MS    = 200;
    localparam int NOTE_CYCLES_DEF = NOTE_TIME_MS * CLK_MHZ * 1000;
    localparam logic [7:0] BCLK_HALF = 8'h28;
    localparam logic [3:0] PIX_DIV   = 4'h9;
    localparam logic [9:0] H_ACTIVE  = 10'h280;
    localparam logic [9:0] H_SYN_BEG = 10'h290;
    localparam logic [9:0] H_SYN_END = 10'h2f0;
    localparam logic [9:0] H_TOTAL   = 10'h320;
    localparam logic [9:0] V_ACTIVE  = 10'h1e0;
    localparam logic [9:0] V_SYN_BEG = 10'h1ea;
    localparam logic [9:0] V_SYN_END = 10'h1ec;
    localparam logic [9:0] V_TOTAL   = 10'h20d;
    localparam logic [9:0] KEY_TOP   = 10'h140;
    localparam int ADDR_W            = 4;
    localparam logic [3:0] REG_CTRL  = 4'h0;
    localparam logic [3:0] REG_STAT  = 4'h4;
    localparam int CTRL_REPLAY       = 0;
    localparam int CTRL_MUTE         = 1;
    localparam logic CTRL_MUTE_RST   = 1'h0;
    localparam logic [7:0] SC_BREAK  = 8'hf0;
    localparam logic [3:0] KB_LAST   = 4'ha;
    localparam logic [3:0] DEMO_LAST = 4'hf;
    localparam logic [15:0] BRASS_HI = 16'h3000;
    localparam logic [15:0] BRASS_LO = 16'hd000;
    typedef enum logic [0:0] {
        DEMO_IDLE = 1'b0,
        DEMO_PLAY = 1'b1
    } demo_state_type;
endpackage

// File: tb/kbd_model.sv
// Purpose: Keyboard that sends scan-code frames on its own link clock.
// Assumes: 48 ns link clock period, lines pulled up when idle.
// Notes:   Clock runs only inside frames.
`timescale 1ns/100ps
module kbd_model (
    output logic kclk,  // Link clock
    output logic kdata  // Link data
);
    initial begin
        kclk  = 1'b1;
        kdata = 1'b1;
    end

    task automatic send(input logic [7:0] b);
        logic [10:0] frm;
        frm = {1'b1, ~^b, b, 1'b0};
        for (int i = 0; i < 11; i++) begin
            kdata = frm[i];
            #12 kclk = 1'b0;
            #24 kclk = 1'b1;
            #12;
        end
        kdata = 1'b1; // Pull-up once released
    endtask

    task automatic release_key(input logic [7:0] b);
        send(8'hf0);
        send(b);
    endtask
endmodule // kbd_model

// File: tb/keyboard_music_synthesizer_tb_top.sv
// Purpose: Self-checking bench for the synthesizer top.
// Assumes: Short note steps via NOTE_CYCLES.
// Notes:   Status read back over the register bus.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
    errors++; $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module keyboard_music_synthesizer_tb_top;
    import synth_pkg::*;
    localparam int NC = 64;
    localparam int PIX_CLKS  = int'(PIX_DIV) + 1;
    localparam int HS_CLKS   = int'(H_SYN_END - H_SYN_BEG) * PIX_CLKS;
    localparam int LINE_CLKS = int'(H_TOTAL) * PIX_CLKS;
    logic        mclk = 1'b0, sys_rst;
    logic        src = 1'b0, timbre = 1'b0, ch1 = 1'b0, ch2 = 1'b0;
    logic        replay_n = 1'b1, rd = 1'b0, wr = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, st;
    logic        waitreq, bclk, lrck, aud_data, kclk, kdata, seen;
    logic        hs, vs, vlow;
    logic [3:0]  vr, vg, vb;
    logic [15:0] left_w;
    int          errors = 0, compares = 0, n;
    logic [7:0]  codes [19] = '{8'h15, 8'h1c, 8'h1d, 8'h1b, 8'h24, 8'h23,
        8'h2b, 8'h2c, 8'h34, 8'h35, 8'h33, 8'h3b, 8'h43, 8'h42, 8'h44,
        8'h4b, 8'h4d, 8'h4c, 8'h3c};

    always #2 mclk = ~mclk;

    kbd_model kbd (.kclk(kclk), .kdata(kdata));

    synth_top #(.NOTE_CYCLES(NC)) dut (
        .MCLK(mclk), .SYS_RST(sys_rst), .KBD_CLK(kclk), .KBD_DATA(kdata),
        .SRC_SEL_SW(src), .TIMBRE_SW(timbre), .CH1_OFF_SW(ch1),
        .CH2_OFF_SW(ch2), .REPLAY_BTN_N(replay_n), .AVS_ADDRESS(addr),
        .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
        .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(waitreq), .AUD_BCLK(bclk), .AUD_LRCK(lrck),
        .AUD_DATA(aud_data), .VGA_HS(hs), .VGA_VS(vs), .VGA_R(vr),
        .VGA_G(vg), .VGA_B(vb));

    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge mclk);
        rd    <= ~w;
        wr    <= w;
        addr  <= a;
        wdata <= d;
        do @(posedge mclk); while (waitreq !== 1'b0);
        q  = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic status();
        repeat (20) @(posedge mclk);
        bus(1'b0, REG_STAT, 32'h0, st);
    endtask

    // Any high data bit over one codec frame after settling one
    task automatic watch_aud();
        repeat (2600) @(posedge mclk);
        seen = 1'b0;
        repeat (2600) @(posedge mclk) if (aud_data === 1'b1) seen = 1'b1;
    endtask

    // Left word of the next frame, taken at bit clock rises
    task automatic grab_left();
        @(posedge lrck);
        for (int i = 15; i >= 0; i--) begin
            @(posedge bclk);
            left_w[i] = aud_data;
        end
    endtask

    // One display line: sync width, vertical sync idle, sky colour shown
    task automatic watch_line();
        n = 0;
        seen = 1'b0;
        vlow = 1'b0;
        repeat (LINE_CLKS) @(posedge mclk) begin
            if (hs === 1'b0) n++;
            if (vs !== 1'b1) vlow = 1'b1;
            if ({vr, vg, vb} === 12'h004) seen = 1'b1;
        end
    endtask

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        repeat (80000) @(posedge mclk);
        errors++;
        print_verdict();
    end

    initial begin
        sys_rst <= 1'b1;
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        status();
        `CHK("status after reset", 32'h0, st)
        bus(1'b1, 4'h8, 32'hffffffff, st);
        bus(1'b0, 4'h8, 32'h0, st);
        `CHK("unmapped read", 32'h0, st)
        $display("Test reset and bus done");

        bus(1'b1, REG_CTRL, 32'h1, st);
        status();
        `CHK("demo playing", 1'b1, st[6])
        `CHK("source demo", 1'b0, st[7])
        repeat (10 * NC) @(posedge mclk);
        replay_n <= 1'b0;
        repeat (4) @(posedge mclk);
        replay_n <= 1'b1;
        repeat (10 * NC) @(posedge mclk);
        status();
        `CHK("demo restarted", 1'b1, st[6])
        repeat (8 * NC) @(posedge mclk);
        status();
        `CHK("demo ended", 1'b0, st[6])
        $display("Test demo done");

        src <= 1'b1;
        for (int i = 0; i < 19; i++) begin
            kbd.send(codes[i]);
            status();
            `CHK("key note", 5'(i + 1), st[4:0])
            `CHK("key held", 1'b1, st[5])
            `CHK("source kbd", 1'b1, st[7])
            kbd.release_key(codes[i]);
            status();
            `CHK("released", 2'b00, {st[5], |st[4:0]})
        end
        $display("Test keys done");

        kbd.send(codes[9]);
        @(posedge lrck);
        n = 0;
        while (lrck === 1'b1 && n < 4000) begin
            @(posedge mclk);
            if (lrck === 1'b1) n++;
        end
        `CHK("left half length", 1280, n)
        watch_aud();
        `CHK("brass sounds", 1'b1, seen)
        grab_left();
        `CHK("brass level", 1'b1, left_w == BRASS_HI || left_w == BRASS_LO)
        timbre <= 1'b1;
        watch_aud();
        `CHK("string sounds", 1'b1, seen)
        grab_left();
        `CHK("string shape", 1'b0, left_w == BRASS_HI || left_w == BRASS_LO)
        ch1 <= 1'b1;
        ch2 <= 1'b1;
        watch_aud();
        `CHK("both off", 1'b0, seen)
        ch2 <= 1'b0;
        watch_aud();
        `CHK("second on", 1'b1, seen)
        ch2 <= 1'b1;
        ch1 <= 1'b0;
        watch_aud();
        `CHK("first on", 1'b1, seen)
        bus(1'b1, REG_CTRL, 32'h2, st);
        watch_aud();
        `CHK("muted", 1'b0, seen)
        bus(1'b0, REG_CTRL, 32'h0, st);
        `CHK("mute readback", 32'h2, st)
        $display("Test audio done");

        @(posedge mclk);
        sys_rst <= 1'b1;
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        status();
        `CHK("mid-run reset", 7'h00, st[6:0])
        bus(1'b0, REG_CTRL, 32'h0, st);
        `CHK("mute cleared", 32'h0, st)
        $display("Test reset mid-run done");

        watch_line();
        `CHK("sync width", HS_CLKS, n)
        `CHK("vsync idle", 1'b0, vlow)
        `CHK("sky shown", 1'b1, seen)
        $display("Test display done");
        print_verdict();
    end
endmodule // keyboard_music_synthesizer_tb_top
